/* File: src/clk_pwr_pkg.sv */
// Purpose: Shared constants, types and register map for clock and power-down control
// Assumes: AXI4-Lite register access, 32-bit data, one byte of data per register
// Notes:   Printed register offsets are indexes; byte address is index times four
// Summary of operation
// - High-speed oscillator disable bit set stops the crystal oscillator and PLL.
// - Keypad clock disable bit set gates off the keypad logic clock.
// - Card clock disable bit set gates off the smart card logic clock.
// - USB clock disable bit set gates off the USB logic clock.
// - RTC uses slow oscillator when enabled, else a clock from main oscillator.
// - VCO clock is (multiplier field times two plus four) times crystal; reset two.
// - CPU clock equals VCO clock divided by twice (divider field plus one).
// - Divider field resets to 0x0C, giving about 3.6923 MHz.
// - Current CPU clock is driven onto a dedicated output pin.
// - Power-down request stops every clock except the slow oscillator.
// - Analog circuits shut down 32 CPU clocks after the power-down request.
// - In power-down, wake sources are ORed and routed via delay to interrupt zero.
// - Wake interrupt restores power to all sections and restarts clocks.
// - After restart, 512 CPU clocks elapse before interrupt zero asserts.
// - Any read of wake interrupt control register clears the wake routing bit; here a write to it in the same cycle keeps the written value.
// - Power-down request overrides individual power control bits while set.
// - RTC keeps running in power-down when clocked from slow oscillator.

package clk_pwr_pkg;

  // ==========================================================================
  // Register map
  localparam int          ADDR_W          = 18;
  localparam logic [15:0] IDX_MCLK_CTL    = 16'h008F;
  localparam logic [15:0] IDX_WAKE_CTL    = 16'hFF94;
  localparam logic [15:0] IDX_CPU_DIV     = 16'hFFA1;
  localparam logic [15:0] IDX_MISC_CTL0   = 16'hFFF1;
  localparam logic [15:0] IDX_CLK_STATUS  = 16'hFFF2;

  localparam logic [7:0]  RST_MCLK_CTL    = 8'h0A;
  localparam logic [7:0]  RST_WAKE_CTL    = 8'h00;
  localparam logic [5:0]  RST_CPU_DIV     = 6'h0C;
  localparam logic [7:0]  RST_MISC_CTL0   = 8'h00;

  // ==========================================================================
  // Field positions
  localparam int MC_HS_OSC_DIS   = 7;
  localparam int MC_KEYPAD_DIS   = 6;
  localparam int MC_CARD_DIS     = 5;
  localparam int MC_USB_DIS      = 4;
  localparam int MC_SLOW_OSC_DIS = 3;
  localparam int MC_MULT_LSB     = 0;
  localparam int WC_ROUTE_SEL    = 7;
  localparam int WC_RTC_IEN      = 5;
  localparam int WC_RTC_FLAG     = 4;
  localparam int WC_USB_IEN      = 3;
  localparam int WC_USB_FLAG     = 2;
  localparam int WC_KP_IEN       = 1;
  localparam int WC_KP_FLAG      = 0;
  localparam int MISC_PD_REQ     = 7;

  // Wake source bit order on the wake input
  localparam int WK_USR  = 0;
  localparam int WK_CARD = 1;
  localparam int WK_USB  = 2;
  localparam int WK_RTC  = 3;
  localparam int WK_KP   = 4;
  localparam int WAKE_N  = 5;

  // ==========================================================================
  // Timing in CPU clock cycles
  localparam logic [9:0] PD_DELAY_CYC   = 10'h020;
  localparam logic [9:0] WAKE_DELAY_CYC = 10'h200;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {ST_RUN, ST_PD_WAIT, ST_PD_OFF, ST_WAKE_DELAY} pd_state_t;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_rsp_t;

  typedef struct packed {
    logic keypad_clk_en;
    logic card_clk_en;
    logic usb_clk_en;
    logic rtc_clk_en;
    logic rtc_clk_from_main;
    logic slow_osc_en;
    logic osc_pll_en;
    logic ref_bias_en;
  } clk_gate_t;

endpackage : clk_pwr_pkg

/* File: src/cpu_clk_divider.sv */
// Purpose: Divides the VCO-rate clock down to the CPU clock
// Assumes: mclk stands for the VCO clock; div never below two
// Notes:   Output period is 2*(div+1) mclk cycles; stops low when run is low

`timescale 1ns/1ns

module cpu_clk_divider
  import clk_pwr_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic       ce,
  input  wire logic       run,
  input  wire logic [5:0] div,
  output logic            tick,
  output logic            clk_out
);

  logic [5:0] count_r;
  logic       clk_r;
  wire        wrap = (count_r >= div);

  // ==========================================================================
  // Half-period counter, compare with >= so a lowered divider never overruns
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      count_r <= 6'h00;
      clk_r   <= 1'b0;
    end else if (ce) begin
      if (!run) begin
        count_r <= 6'h00;
        clk_r   <= 1'b0;
      end else if (wrap) begin
        count_r <= 6'h00;
        clk_r   <= ~clk_r;
      end else begin
        count_r <= count_r + 6'h01;
      end
    end
  end

  assign tick    = ce & run & wrap & ~clk_r;
  assign clk_out = clk_r;

endmodule : cpu_clk_divider

/* File: src/clk_pwr_ctrl.sv */
// Purpose: Clock gating, CPU clock division and power-down sequencing
// Assumes: Crystal oscillator and PLL are analog and driven by the enables here
// Notes:   Wake sources come from other domains and are synchronised
//
// Register access over AXI4-Lite was left to the implementer.

`timescale 1ns/1ns

module clk_pwr_ctrl
  import clk_pwr_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  input  wire axil_req_t   axi_req,
  output axil_rsp_t        axi_rsp,
  input  wire logic [4:0]  wake_src,
  output clk_gate_t        gates,
  output logic [2:0]       vco_mult_sel,
  output logic             cpu_clock_out,
  output logic             cpu_clk_en,
  output logic             power_down_active,
  output logic             ext_irq_zero
);

  // ==========================================================================
  // Address decode helper, shared by read and write paths
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [15:0] idx);
    reg_hit = (addr == {idx, 2'b00});
  endfunction : reg_hit

  // ==========================================================================
  // Register state
  logic [7:0]  mclk_ctl_r;
  logic [5:0]  cpu_clk_div;
  logic        wake_route_sel;
  logic        rtc_irq_enable;
  logic        usb_irq_enable;
  logic        keypad_irq_enable;
  logic        power_down_req;

  pd_state_t   state_r;
  pd_state_t   state_nxt;
  logic [9:0]  cnt_r;
  logic [9:0]  cnt_nxt;
  logic        irq_r;

  // Bus channel state
  logic              aw_got_r;
  logic              w_got_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [7:0]        wbyte_r;
  logic              wlane_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              rvalid_r;
  logic [31:0]       rdata_r;
  logic [1:0]        rresp_r;

  // ==========================================================================
  // Wake source synchroniser: three stages, change accepted when last two agree
  logic [WAKE_N-1:0] wk_s1_r;
  logic [WAKE_N-1:0] wk_s2_r;
  logic [WAKE_N-1:0] wk_s3_r;
  logic [WAKE_N-1:0] wake_lvl_r;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      wk_s1_r    <= '0;
      wk_s2_r    <= '0;
      wk_s3_r    <= '0;
      wake_lvl_r <= '0;
    end else if (ce) begin
      wk_s1_r    <= wake_src;
      wk_s2_r    <= wk_s1_r;
      wk_s3_r    <= wk_s2_r;
      wake_lvl_r <= (wk_s2_r & wk_s3_r) | (wake_lvl_r & (wk_s2_r | wk_s3_r));
    end
  end

  // All sources ORed onto the single wake path, only when routing is armed
  wire wake_any = wake_route_sel & (|wake_lvl_r);

  // ==========================================================================
  // CPU clock divider
  wire pd_on      = (state_r != ST_RUN);
  wire analog_off = (state_r == ST_PD_OFF);
  wire hs_osc_off = mclk_ctl_r[MC_HS_OSC_DIS] & ~pd_on;
  wire cpu_run    = ~analog_off & ~hs_osc_off;
  wire cpu_tick;
  wire cpu_clk_raw;

  cpu_clk_divider u_div (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .ce      (ce),
    .run     (cpu_run),
    .div     (cpu_clk_div),
    .tick    (cpu_tick),
    .clk_out (cpu_clk_raw)
  );

  assign cpu_clock_out = cpu_clk_raw;
  assign cpu_clk_en    = cpu_tick;

  // ==========================================================================
  // Power-down sequencer
  wire cnt_last_pd   = (cnt_r == PD_DELAY_CYC - 10'h001);
  wire cnt_last_wake = (cnt_r == WAKE_DELAY_CYC - 10'h001);
  wire seq_done      = (state_r == ST_WAKE_DELAY) & cpu_tick & cnt_last_wake;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    unique case (state_r)
      ST_RUN: begin
        cnt_nxt = 10'h000;
        if (power_down_req) begin
          state_nxt = ST_PD_WAIT;
        end
      end
      ST_PD_WAIT: begin
        if (cpu_tick) begin
          if (cnt_last_pd) begin
            state_nxt = ST_PD_OFF;
            cnt_nxt   = 10'h000;
          end else begin
            cnt_nxt = cnt_r + 10'h001;
          end
        end
      end
      ST_PD_OFF: begin
        cnt_nxt = 10'h000;
        if (wake_any) begin
          state_nxt = ST_WAKE_DELAY;
        end
      end
      ST_WAKE_DELAY: begin
        if (cpu_tick) begin
          if (cnt_last_wake) begin
            state_nxt = ST_RUN;
            cnt_nxt   = 10'h000;
          end else begin
            cnt_nxt = cnt_r + 10'h001;
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state_r <= ST_RUN;
      cnt_r   <= 10'h000;
    end else if (ce) begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // ==========================================================================
  // Bus decode
  wire aw_take  = axi_req.awvalid & ~aw_got_r & ~bvalid_r;
  wire w_take   = axi_req.wvalid & ~w_got_r & ~bvalid_r;
  wire wr_go    = aw_got_r & w_got_r;
  wire ar_take  = axi_req.arvalid & ~rvalid_r;

  wire wr_mclk  = wr_go & wlane_r & reg_hit(awaddr_r, IDX_MCLK_CTL);
  wire wr_wake  = wr_go & wlane_r & reg_hit(awaddr_r, IDX_WAKE_CTL);
  wire wr_div   = wr_go & wlane_r & reg_hit(awaddr_r, IDX_CPU_DIV);
  wire wr_misc  = wr_go & wlane_r & reg_hit(awaddr_r, IDX_MISC_CTL0);
  wire wr_map   = reg_hit(awaddr_r, IDX_MCLK_CTL) | reg_hit(awaddr_r, IDX_WAKE_CTL)
                | reg_hit(awaddr_r, IDX_CPU_DIV)  | reg_hit(awaddr_r, IDX_MISC_CTL0)
                | reg_hit(awaddr_r, IDX_CLK_STATUS);

  wire rd_mclk  = reg_hit(axi_req.araddr, IDX_MCLK_CTL);
  wire rd_wake  = reg_hit(axi_req.araddr, IDX_WAKE_CTL);
  wire rd_div   = reg_hit(axi_req.araddr, IDX_CPU_DIV);
  wire rd_misc  = reg_hit(axi_req.araddr, IDX_MISC_CTL0);
  wire rd_stat  = reg_hit(axi_req.araddr, IDX_CLK_STATUS);
  wire rd_map   = rd_mclk | rd_wake | rd_div | rd_misc | rd_stat;

  // Flags read back as the synchronised source levels
  wire [7:0] wake_ctl_val = {wake_route_sel, 1'b0,
                             rtc_irq_enable, wake_lvl_r[WK_RTC],
                             usb_irq_enable, wake_lvl_r[WK_USB],
                             keypad_irq_enable, wake_lvl_r[WK_KP]};
  wire [7:0] status_val   = {4'h0, irq_r, (state_r == ST_WAKE_DELAY), analog_off, pd_on};
  wire [7:0] rd_byte      = rd_mclk ? mclk_ctl_r
                          : rd_wake ? wake_ctl_val
                          : rd_div  ? {2'b00, cpu_clk_div}
                          : rd_misc ? {power_down_req, 7'h00}
                          : rd_stat ? status_val
                          : 8'h00;

  // ==========================================================================
  // Write and read channels
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      awaddr_r <= '0;
      wbyte_r  <= 8'h00;
      wlane_r  <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (ce) begin
      if (aw_take) begin
        aw_got_r <= 1'b1;
        awaddr_r <= axi_req.awaddr;
      end
      if (w_take) begin
        w_got_r <= 1'b1;
        wbyte_r <= axi_req.wdata[7:0];
        wlane_r <= axi_req.wstrb[0];
      end
      if (wr_go) begin
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r  <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r & axi_req.bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= RESP_OKAY;
    end else if (ce) begin
      if (ar_take) begin
        rvalid_r <= 1'b1;
        rdata_r  <= {24'h00_0000, rd_byte};
        rresp_r  <= rd_map ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_r & axi_req.rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // Ready follows ce so that nothing is offered as taken while the state is frozen
  assign axi_rsp.awready = ce & ~aw_got_r & ~bvalid_r;
  assign axi_rsp.wready  = ce & ~w_got_r & ~bvalid_r;
  assign axi_rsp.bvalid  = bvalid_r;
  assign axi_rsp.bresp   = bresp_r;
  assign axi_rsp.arready = ce & ~rvalid_r;
  assign axi_rsp.rvalid  = rvalid_r;
  assign axi_rsp.rdata   = rdata_r;
  assign axi_rsp.rresp   = rresp_r;

  // ==========================================================================
  // Control registers
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      mclk_ctl_r  <= RST_MCLK_CTL;
      cpu_clk_div <= RST_CPU_DIV;
    end else if (ce) begin
      if (wr_mclk) begin
        mclk_ctl_r <= wbyte_r;
      end
      // Values of zero or one are stored as written; the divider would run too fast
      if (wr_div) begin
        cpu_clk_div <= wbyte_r[5:0];
      end
    end
  end

  wire rd_wake_take = ar_take & rd_wake;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      wake_route_sel    <= RST_WAKE_CTL[WC_ROUTE_SEL];
      rtc_irq_enable    <= RST_WAKE_CTL[WC_RTC_IEN];
      usb_irq_enable    <= RST_WAKE_CTL[WC_USB_IEN];
      keypad_irq_enable <= RST_WAKE_CTL[WC_KP_IEN];
    end else if (ce) begin
      // A write in the same cycle as a read keeps the written value
      if (wr_wake) begin
        wake_route_sel    <= wbyte_r[WC_ROUTE_SEL];
        rtc_irq_enable    <= wbyte_r[WC_RTC_IEN];
        usb_irq_enable    <= wbyte_r[WC_USB_IEN];
        keypad_irq_enable <= wbyte_r[WC_KP_IEN];
      end else if (rd_wake_take) begin
        wake_route_sel <= 1'b0;
      end
    end
  end

  // Request self-clears when the wake delay expires; software cannot cancel mid-sequence
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      power_down_req <= RST_MISC_CTL0[MISC_PD_REQ];
    end else if (ce) begin
      if (wr_misc & wbyte_r[MISC_PD_REQ]) begin
        power_down_req <= 1'b1;
      end else if (seq_done) begin
        power_down_req <= 1'b0;
      end
    end
  end

  // Interrupt stays low through the whole wake delay, then holds until the wake control register is read or power-down is requested again
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      irq_r <= 1'b0;
    end else if (ce) begin
      if (seq_done) begin
        irq_r <= 1'b1;
      end else if (rd_wake_take | power_down_req) begin
        irq_r <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Clock gates and analog enables, registered
  clk_gate_t gates_nxt;
  clk_gate_t gates_r;

  always_comb begin
    gates_nxt.keypad_clk_en     = ~pd_on & ~mclk_ctl_r[MC_KEYPAD_DIS];
    gates_nxt.card_clk_en       = ~pd_on & ~mclk_ctl_r[MC_CARD_DIS];
    gates_nxt.usb_clk_en        = ~pd_on & ~mclk_ctl_r[MC_USB_DIS];
    gates_nxt.slow_osc_en       = ~mclk_ctl_r[MC_SLOW_OSC_DIS];
    gates_nxt.rtc_clk_from_main = mclk_ctl_r[MC_SLOW_OSC_DIS];
    // Main-derived RTC clock dies with the oscillator; slow oscillator keeps it alive
    gates_nxt.rtc_clk_en        = ~mclk_ctl_r[MC_SLOW_OSC_DIS] | ~analog_off;
    gates_nxt.osc_pll_en        = ~analog_off & ~hs_osc_off;
    gates_nxt.ref_bias_en       = ~analog_off;
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      gates_r      <= '0;
      vco_mult_sel <= RST_MCLK_CTL[MC_MULT_LSB +: 3];
    end else if (ce) begin
      gates_r      <= gates_nxt;
      vco_mult_sel <= mclk_ctl_r[MC_MULT_LSB +: 3];
    end
  end

  assign gates             = gates_r;
  assign power_down_active = pd_on;
  assign ext_irq_zero      = irq_r;

endmodule : clk_pwr_ctrl

/* File: test/clk_pwr_ctrl_checker.sv */
// Purpose: Port-level checks of clock gating and power-down sequencing
// Assumes: ce low only while the bus is idle; bready/rready held high by the bench
// Notes:   Pulse counters tolerate the one-cycle lag of the registered gates

`timescale 1ns/1ns

module clk_pwr_ctrl_checker
  import clk_pwr_pkg::*;
(
  input wire logic       mclk,
  input wire logic       rst_b,
  input wire logic       ce,
  input wire axil_req_t  axi_req,
  input wire axil_rsp_t  axi_rsp,
  input wire logic [4:0] wake_src,
  input wire clk_gate_t  gates,
  input wire logic [2:0] vco_mult_sel,
  input wire logic       cpu_clock_out,
  input wire logic       cpu_clk_en,
  input wire logic       power_down_active,
  input wire logic       ext_irq_zero
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  // ==========================================================================
  // Pulse counters
  logic [9:0] pd_cnt_r;
  logic [9:0] wk_cnt_r;

  always_ff @(posedge mclk) begin
    if (!rst_b || !power_down_active) pd_cnt_r <= '0;
    else if (cpu_clk_en) pd_cnt_r <= pd_cnt_r + 10'h001;
  end

  // Cleared while analog is off, so each wake delay is counted from zero
  always_ff @(posedge mclk) begin
    if (!rst_b || !gates.osc_pll_en) wk_cnt_r <= '0;
    else if (cpu_clk_en && power_down_active) wk_cnt_r <= wk_cnt_r + 10'h001;
  end

  // ==========================================================================
  // Assertions
  sequence aw_w_take;
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
  endsequence
  sequence ar_take;
    axi_req.arvalid && axi_rsp.arready;
  endsequence

  clk_edge_a: assert property (cpu_clk_en |=> $rose(cpu_clock_out))
    else $error("cpu clock did not rise after enable pulse");
  clk_cause_a: assert property ($rose(cpu_clock_out) |-> $past(cpu_clk_en))
    else $error("cpu clock rose without enable pulse");
  pd_gate_a: assert property ($rose(power_down_active) |=>
    !gates.keypad_clk_en && !gates.card_clk_en && !gates.usb_clk_en)
    else $error("peripheral clocks still on in power-down");
  analog_wait_a: assert property (power_down_active && !gates.ref_bias_en |->
    pd_cnt_r >= 10'h020) else $error("analog shut down too early");
  irq_delay_a: assert property ($rose(ext_irq_zero) |->
    wk_cnt_r >= 10'h1FE && wk_cnt_r <= 10'h202) else $error("wake delay count wrong");
  irq_in_pd_a: assert property (power_down_active |-> !ext_irq_zero)
    else $error("interrupt zero high during power-down");
  rtc_keep_a: assert property (power_down_active && !gates.osc_pll_en |->
    gates.rtc_clk_en == gates.slow_osc_en) else $error("rtc clock wrong in power-down");
  // Write lands one edge after both channels are taken, response shows the edge after
  wr_resp_a: assert property (aw_w_take |=> ##1 axi_rsp.bvalid ##1 !axi_rsp.bvalid)
    else $error("write response timing wrong");
  rd_resp_a: assert property (ar_take |=> axi_rsp.rvalid ##1 !axi_rsp.rvalid)
    else $error("read response timing wrong");
endmodule : clk_pwr_ctrl_checker

bind clk_pwr_ctrl clk_pwr_ctrl_checker chk_i (.mclk(mclk), .rst_b(rst_b), .ce(ce),
  .axi_req(axi_req), .axi_rsp(axi_rsp), .wake_src(wake_src), .gates(gates),
  .vco_mult_sel(vco_mult_sel), .cpu_clock_out(cpu_clock_out), .cpu_clk_en(cpu_clk_en),
  .power_down_active(power_down_active), .ext_irq_zero(ext_irq_zero));

/* File: test/test_clock_gating_and_power_down.sv */
// Purpose: Self-checking bench for clock gating and power-down control
// Assumes: Register model in integers; bready and rready held high throughout
// Notes:   Divider set to two during power-down runs to keep the wake delay short

`timescale 1ns/1ns

module test_clock_gating_and_power_down
  import clk_pwr_pkg::*;
;
  localparam logic [17:0] A_MC  = {IDX_MCLK_CTL, 2'b00};
  localparam logic [17:0] A_WK  = {IDX_WAKE_CTL, 2'b00};
  localparam logic [17:0] A_DV  = {IDX_CPU_DIV, 2'b00};
  localparam logic [17:0] A_MS  = {IDX_MISC_CTL0, 2'b00};
  localparam logic [17:0] A_ST  = {IDX_CLK_STATUS, 2'b00};
  localparam logic [17:0] A_BAD = 18'h0_0000;

  logic        mclk, rst_b, ce, cpu_clock_out, cpu_clk_en, power_down_active, ext_irq_zero;
  axil_req_t   axi_req;
  axil_rsp_t   axi_rsp;
  logic [4:0]  wake_src;
  clk_gate_t   gates;
  logic [2:0]  vco_mult_sel;
  logic [31:0] rd_d;
  logic [1:0]  rsp;
  int          n_mismatch, checks_done, cyc, m_mc, m_dv, n, i;
  int          dq[$] = '{2, 12, 63};

  clk_pwr_ctrl DUT (.mclk(mclk), .rst_b(rst_b), .ce(ce), .axi_req(axi_req),
    .axi_rsp(axi_rsp), .wake_src(wake_src), .gates(gates), .vco_mult_sel(vco_mult_sel),
    .cpu_clock_out(cpu_clock_out), .cpu_clk_en(cpu_clk_en),
    .power_down_active(power_down_active), .ext_irq_zero(ext_irq_zero));

  // ==========================================================================
  // Clock, timeout and reporting
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  task print_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // ==========================================================================
  // Bus tasks; AW and W offered together, each dropped once taken
  task automatic wr(input logic [17:0] a, input logic [7:0] d, input logic [3:0] s);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr  <= a;
    axi_req.wvalid  <= 1'b1;
    axi_req.wdata   <= {24'h00_0000, d};
    axi_req.wstrb   <= s;
    while (!(ta && tw)) begin
      @(posedge mclk);
      if (axi_rsp.awready) begin
        ta = 1'b1;
        axi_req.awvalid <= 1'b0;
      end
      if (axi_rsp.wready) begin
        tw = 1'b1;
        axi_req.wvalid <= 1'b0;
      end
    end
    do @(posedge mclk); while (!axi_rsp.bvalid);
    rsp = axi_rsp.bresp;
  endtask : wr

  task automatic rd(input logic [17:0] a);
    axi_req.arvalid <= 1'b1;
    axi_req.araddr  <= a;
    do @(posedge mclk); while (!axi_rsp.arready);
    axi_req.arvalid <= 1'b0;
    do @(posedge mclk); while (!axi_rsp.rvalid);
    rd_d = axi_rsp.rdata;
    rsp  = axi_rsp.rresp;
  endtask : rd

  task automatic rchk(input string nm, input logic [17:0] a, input logic [7:0] e);
    rd(a);
    chk(nm, rd_d, {24'h00_0000, e});
  endtask : rchk

  // Gates are registered, so let the control settle first
  task automatic gchk;
    logic [8:0] s, e;
    repeat (3) @(posedge mclk);
    s = {gates.keypad_clk_en, gates.card_clk_en, gates.usb_clk_en, gates.slow_osc_en,
         gates.rtc_clk_from_main, gates.osc_pll_en, vco_mult_sel};
    e = {~m_mc[6], ~m_mc[5], ~m_mc[4], ~m_mc[3], m_mc[3], ~m_mc[7], 3'(m_mc)};
    chk("gates", 32'(s), 32'(e));
  endtask : gchk

  task automatic period;
    n = 0;
    while (!cpu_clk_en) @(posedge mclk);
    do begin
      @(posedge mclk);
      n++;
    end while (!cpu_clk_en);
  endtask : period

  // ==========================================================================
  // Main sequence
  initial begin
    rst_b    = 1'b0;
    ce       = 1'b1;
    wake_src = 5'h00;
    axi_req  = '0;
    axi_req.bready = 1'b1;
    axi_req.rready = 1'b1;
    m_mc = 8'h0A;
    void'($urandom(16));
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    rchk("mclk_ctl", A_MC, 8'h0A);
    rchk("cpu_div", A_DV, 8'h0C);
    rchk("wake_ctl", A_WK, 8'h00);
    gchk();
    rd(A_BAD);
    chk("bad_rd", 32'(rsp), 32'(RESP_SLVERR));
    wr(A_BAD, 8'hFF, 4'h1);
    chk("bad_wr", 32'(rsp), 32'(RESP_SLVERR));
    wr(A_MC, 8'h5A, 4'h0);
    rchk("no_strb", A_MC, 8'h0A);
    for (i = 0; i < 6; i++) begin
      m_mc = $urandom % 256;
      m_dv = 2 + $urandom % 62;
      wr(A_MC, 8'(m_mc), 4'h1);
      wr(A_DV, 8'(m_dv + 64 * ($urandom % 4)), 4'h1);
      rchk("mclk_ctl", A_MC, 8'(m_mc));
      rchk("cpu_div", A_DV, 8'(m_dv));
      gchk();
    end
    m_mc = 8'h8A;
    wr(A_MC, 8'(m_mc), 4'h1);
    repeat (10) @(posedge mclk);
    n = 0;
    repeat (100) begin
      @(posedge mclk);
      if (cpu_clk_en) n++;
    end
    chk("hs_stop", 32'(n), 0);
    m_mc = 8'h0A;
    wr(A_MC, 8'(m_mc), 4'h1);
    foreach (dq[k]) begin
      wr(A_DV, 8'(dq[k]), 4'h1);
      period();
      period();
      chk("period", 32'(n), 32'(2 * (dq[k] + 1)));
    end
    for (i = 0; i < 5; i++) begin
      m_mc = 8'h02 + 8 * (i % 2);
      wr(A_MC, 8'(m_mc), 4'h1);
      wr(A_DV, 8'h02, 4'h1);
      // Clock enable low must freeze the divider and its pulse
      ce <= 1'b0;
      @(posedge mclk);
      m_dv = cpu_clock_out;
      n = 0;
      repeat (40) begin
        @(posedge mclk);
        if (cpu_clk_en || cpu_clock_out !== m_dv[0]) n++;
      end
      ce <= 1'b1;
      chk("ce_hold", 32'(n), 0);
      wr(A_WK, 8'h80, 4'h1);
      wr(A_MS, 8'h80, 4'h1);
      n = 0;
      while (gates.osc_pll_en) begin
        @(posedge mclk);
        if (cpu_clk_en) n++;
      end
      chk("pd_delay", 32'(n >= 31 && n <= 33), 1);
      repeat (20) @(posedge mclk);
      chk("pd_state", 32'({power_down_active, gates.keypad_clk_en, gates.card_clk_en,
        gates.usb_clk_en, gates.ref_bias_en, cpu_clock_out, ext_irq_zero,
        gates.rtc_clk_en}), 32'({7'b100_0000, i % 2 == 0}));
      rchk("pd_status", A_ST, 8'h03);
      wake_src <= 5'h01 << i;
      while (!gates.osc_pll_en) @(posedge mclk);
      n = 0;
      while (!ext_irq_zero) begin
        @(posedge mclk);
        if (cpu_clk_en) n++;
      end
      chk("wake_delay", 32'(n >= 511 && n <= 513), 1);
      wake_src <= 5'h00;
      repeat (8) @(posedge mclk);
      chk("awake", 32'({power_down_active, gates.keypad_clk_en, gates.usb_clk_en,
        gates.osc_pll_en, gates.ref_bias_en}), 32'h0000_000F);
      rchk("irq_status", A_ST, 8'h08);
      rchk("route_set", A_WK, 8'h80);
      rchk("route_clr", A_WK, 8'h00);
      chk("irq_clr", 32'(ext_irq_zero), 0);
    end
    print_verdict();
  end
endmodule : test_clock_gating_and_power_down
